// *** rsp_top.sv ***
// rate sensor output processing: sampling, averaging, trim, output words
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// one moving-average stage with 2^m taps
// ----------------------------------------------------------------------------
module rsp_avg_stage #(
  parameter int W = 18,
  parameter int MAXM = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic clear_i,
  input wire logic [2:0] m_i,
  input wire logic signed [W-1:0] din_i,
  output logic signed [W-1:0] dout_o
);
  localparam int D = 1 << MAXM;
  logic signed [W-1:0] mem [D];
  logic [MAXM-1:0] ptr_reg;
  logic [MAXM:0] fill_reg;
  logic [MAXM:0] n;
  logic signed [W-1:0] old;
  logic signed [W+MAXM-1:0] sum_reg;
  logic signed [W+MAXM-1:0] sum_next;
  logic signed [W+MAXM-1:0] avg;

  // entries not yet written count as zero, so a cleared stage needs no flush
  always_comb begin
    n = (MAXM+1)'(1) << m_i;
    old = (fill_reg >= n) ? mem[ptr_reg - n[MAXM-1:0]] : '0;
    sum_next = sum_reg + din_i - old;
    avg = sum_next >>> m_i;
  end

  always_ff @(posedge clk_i) begin
    if (en_i) begin
      mem[ptr_reg] <= din_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      ptr_reg <= '0;
      fill_reg <= '0;
      sum_reg <= '0;
    end else if (en_i) begin
      ptr_reg <= ptr_reg + 1'b1;
      if (fill_reg < n) begin
        fill_reg <= fill_reg + 1'b1;
      end
      sum_reg <= sum_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_o <= '0;
    end else if (en_i) begin
      dout_o <= avg[W-1:0];
    end
  end
endmodule

// ----------------------------------------------------------------------------
// top
// ----------------------------------------------------------------------------
module rsp_top #(
  parameter int unsigned FAST_CYC = rsp_pkg::FAST_CYC,
  parameter int unsigned TB_SHORT_CYC = rsp_pkg::TB_SHORT_CYC,
  parameter int unsigned TB_LONG_CYC = rsp_pkg::TB_LONG_CYC,
  parameter int unsigned ANGLE_UNIT = rsp_pkg::ANGLE_UNIT,
  parameter int MAXM = 7
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // register port
  input wire logic [6:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  // converter and sensor samples
  input wire logic signed [15:0] RATE_RAW_I,
  input wire logic [11:0] SUPPLY_I,
  input wire logic [11:0] TEMP_I,
  input wire logic [11:0] AUX_I,
  input wire logic [15:0] DIAG_I,
  // controls and events
  output logic POLE_WIDE_O,
  output logic SAMPLE_O,
  output logic IRQ_O
);
  localparam int FW = 18;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic [7:0] smpl_reg;
  rsp_pkg::rsp_sens_t sens_reg;
  rsp_pkg::rsp_sens_t sens_next;
  logic [11:0] off_reg;
  logic [11:0] scale_reg;
  logic [rsp_pkg::IRQ_W-1:0] irq_st_reg;
  logic [rsp_pkg::IRQ_W-1:0] irq_mask_reg;

  // range write may raise the tap code; the clamp uses the range written in the same word
  always_comb begin
    sens_next.range = WDATA_I[10:8];
    sens_next.pole = WDATA_I[rsp_pkg::SA_POLE_BIT];
    sens_next.taps = WDATA_I[2:0];
    if (sens_next.range == rsp_pkg::RANGE_160 && sens_next.taps < rsp_pkg::MIN_TAP_160) begin
      sens_next.taps = rsp_pkg::MIN_TAP_160;
    end
    if (sens_next.range == rsp_pkg::RANGE_80 && sens_next.taps < rsp_pkg::MIN_TAP_80) begin
      sens_next.taps = rsp_pkg::MIN_TAP_80;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      smpl_reg <= rsp_pkg::SMPL_RST[7:0];
      sens_reg.range <= rsp_pkg::SENS_RST[10:8];
      sens_reg.pole <= rsp_pkg::SENS_RST[rsp_pkg::SA_POLE_BIT];
      sens_reg.taps <= rsp_pkg::SENS_RST[2:0];
      off_reg <= rsp_pkg::OFF_RST;
      scale_reg <= rsp_pkg::SCALE_RST;
      irq_mask_reg <= '0;
    end else if (WR_I) begin
      unique case (ADDR_I)
        rsp_pkg::A_SMPL: smpl_reg <= WDATA_I[7:0];
        rsp_pkg::A_SENS: sens_reg <= sens_next;
        rsp_pkg::A_OFF: off_reg <= WDATA_I[11:0];
        rsp_pkg::A_SCALE: scale_reg <= WDATA_I[11:0];
        rsp_pkg::A_IRQ_MASK: irq_mask_reg <= WDATA_I[rsp_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign POLE_WIDE_O = sens_reg.pole;

  // ------------------------------------------------------------
  // sample-rate generator
  // ------------------------------------------------------------
  logic [20:0] base_cnt_reg;
  logic [6:0] inc_cnt_reg;
  logic [20:0] base_lim;
  logic [6:0] inc_lim;
  logic base_tick;
  logic tick;
  logic tick_d_reg;

  always_comb begin
    if (smpl_reg == 8'h00) begin
      base_lim = 21'(FAST_CYC - 1);
      inc_lim = 7'h00;
    end else begin
      base_lim = smpl_reg[rsp_pkg::SP_BASE_BIT] ? 21'(TB_LONG_CYC - 1)
                                                 : 21'(TB_SHORT_CYC - 1);
      inc_lim = smpl_reg[6:0];
    end
    base_tick = (base_cnt_reg >= base_lim);
    tick = base_tick && (inc_cnt_reg >= inc_lim);
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      base_cnt_reg <= '0;
      inc_cnt_reg <= '0;
    end else if (base_tick) begin
      base_cnt_reg <= '0;
      inc_cnt_reg <= tick ? 7'h00 : inc_cnt_reg + 7'h01;
    end else begin
      base_cnt_reg <= base_cnt_reg + 21'h000001;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      tick_d_reg <= 1'b0;
    end else begin
      tick_d_reg <= tick;
    end
  end

  assign SAMPLE_O = tick_d_reg;

  // ------------------------------------------------------------
  // averaging filter
  // ------------------------------------------------------------
  logic [2:0] taps_prev_reg;
  logic tap_change;
  logic signed [FW-1:0] st1_out;
  logic signed [FW-1:0] st2_out;

  // a tap change restarts both stages instead of mixing two window lengths
  assign tap_change = (taps_prev_reg != sens_reg.taps);

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      taps_prev_reg <= rsp_pkg::SENS_RST[2:0];
    end else begin
      taps_prev_reg <= sens_reg.taps;
    end
  end

  rsp_avg_stage #(.W(FW), .MAXM(MAXM)) u_stage1 (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .en_i(tick),
    .clear_i(tap_change),
    .m_i(sens_reg.taps),
    .din_i(FW'(RATE_RAW_I)),
    .dout_o(st1_out)
  );

  rsp_avg_stage #(.W(FW), .MAXM(MAXM)) u_stage2 (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .en_i(tick),
    .clear_i(tap_change),
    .m_i(sens_reg.taps),
    .din_i(st1_out),
    .dout_o(st2_out)
  );

  // ------------------------------------------------------------
  // trim and range scaling
  // ------------------------------------------------------------
  logic signed [18:0] with_off;
  logic signed [31:0] prod;
  logic signed [20:0] fine;
  logic signed [20:0] ranged;
  logic [1:0] shift;
  logic [13:0] rate_sat;

  always_comb begin
    with_off = 19'(st2_out) + 19'(signed'(off_reg));
    prod = 32'(with_off) * 32'(signed'({1'b0, scale_reg}));
    fine = 21'(prod >>> rsp_pkg::SCALE_FRAC);
    unique case (sens_reg.range)
      rsp_pkg::RANGE_160: shift = rsp_pkg::SH_160;
      rsp_pkg::RANGE_80: shift = rsp_pkg::SH_80;
      default: shift = rsp_pkg::SH_320;
    endcase
    ranged = fine >>> shift;
    if (ranged > rsp_pkg::RATE_POS) begin
      rate_sat = rsp_pkg::RATE_POS[13:0];
    end else if (ranged < rsp_pkg::RATE_NEG) begin
      rate_sat = rsp_pkg::RATE_NEG[13:0];
    end else begin
      rate_sat = ranged[13:0];
    end
  end

  // ------------------------------------------------------------
  // output words
  // ------------------------------------------------------------
  logic [13:0] rate_reg;
  logic signed [20:0] rate_fine_reg;
  logic [11:0] supply_reg;
  logic [11:0] temp_reg;
  logic [11:0] aux_reg;
  logic [4:0] new_flag_reg;
  logic fault;
  logic fault_d_reg;

  assign fault = |DIAG_I;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rate_reg <= '0;
      rate_fine_reg <= '0;
      supply_reg <= '0;
      temp_reg <= '0;
      aux_reg <= '0;
    end else if (tick_d_reg) begin
      rate_reg <= rate_sat;
      rate_fine_reg <= fine;
      supply_reg <= SUPPLY_I;
      temp_reg <= TEMP_I;
      aux_reg <= AUX_I;
    end
  end

  // new flags: 0 supply, 1 rate, 2 aux, 3 temp, 4 angle; a fresh sample beats the read
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      new_flag_reg <= '0;
    end else if (tick_d_reg) begin
      new_flag_reg <= '1;
    end else if (RD_I) begin
      unique case (ADDR_I)
        rsp_pkg::A_SUPPLY: new_flag_reg[0] <= 1'b0;
        rsp_pkg::A_RATE: new_flag_reg[1] <= 1'b0;
        rsp_pkg::A_AUX: new_flag_reg[2] <= 1'b0;
        rsp_pkg::A_TEMP: new_flag_reg[3] <= 1'b0;
        rsp_pkg::A_ANGLE: new_flag_reg[4] <= 1'b0;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // angle accumulator
  // ------------------------------------------------------------
  logic signed [31:0] phase_reg;
  logic signed [31:0] phase_sum;
  logic [13:0] angle_reg;

  // rate integrates every clock; one angle step per ANGLE_UNIT of rate*cycles
  assign phase_sum = phase_reg + 32'(rate_fine_reg);

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      phase_reg <= '0;
      angle_reg <= '0;
    end else if (WR_I && ADDR_I == rsp_pkg::A_ANGLE) begin
      phase_reg <= '0;
      angle_reg <= WDATA_I[13:0];
    end else if (phase_sum >= signed'(ANGLE_UNIT)) begin
      phase_reg <= phase_sum - signed'(ANGLE_UNIT);
      angle_reg <= (angle_reg >= rsp_pkg::ANGLE_MAX) ? 14'h0000 : angle_reg + 14'h0001;
    end else if (phase_sum <= -signed'(ANGLE_UNIT)) begin
      phase_reg <= phase_sum + signed'(ANGLE_UNIT);
      angle_reg <= (angle_reg == 14'h0000) ? rsp_pkg::ANGLE_MAX : angle_reg - 14'h0001;
    end else begin
      phase_reg <= phase_sum;
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  logic [rsp_pkg::IRQ_W-1:0] irq_set;
  logic [rsp_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[rsp_pkg::IRQ_SAMPLE] = tick_d_reg;
    irq_set[rsp_pkg::IRQ_FAULT] = fault && !fault_d_reg;
    irq_clr = (WR_I && ADDR_I == rsp_pkg::A_IRQ_ST) ? WDATA_I[rsp_pkg::IRQ_W-1:0] : '0;
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      irq_st_reg <= '0;
      fault_d_reg <= 1'b0;
    end else begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
      fault_d_reg <= fault;
    end
  end

  assign IRQ_O = |(irq_st_reg & irq_mask_reg);

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  rsp_pkg::rsp_word_t word;

  always_comb begin
    word.new_sample_flag = 1'b0;
    word.fault_summary_flag = fault;
    word.data = '0;
    unique case (ADDR_I)
      rsp_pkg::A_SUPPLY: word = '{new_flag_reg[0], fault, {2'h0, supply_reg}};
      rsp_pkg::A_RATE: word = '{new_flag_reg[1], fault, rate_reg};
      rsp_pkg::A_AUX: word = '{new_flag_reg[2], fault, {2'h0, aux_reg}};
      rsp_pkg::A_TEMP: word = '{new_flag_reg[3], fault, {2'h0, temp_reg}};
      rsp_pkg::A_ANGLE: word = '{new_flag_reg[4], fault, angle_reg};
      rsp_pkg::A_OFF: word = 16'(off_reg);
      rsp_pkg::A_SCALE: word = 16'(scale_reg);
      rsp_pkg::A_SMPL: word = 16'(smpl_reg);
      rsp_pkg::A_SENS: word = {5'h00, sens_reg.range, sens_reg.pole, 4'h0, sens_reg.taps};
      rsp_pkg::A_DIAG: word = DIAG_I;
      rsp_pkg::A_IRQ_ST: word = 16'(irq_st_reg);
      rsp_pkg::A_IRQ_MASK: word = 16'(irq_mask_reg);
      default: word = '0;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      RDATA_O <= '0;
    end else if (RD_I) begin
      RDATA_O <= word;
    end else begin
      RDATA_O <= '0;
    end
  end
endmodule

`default_nettype wire

// *** rsp_pkg.sv ***
// constants, register map and types of the rate sensor output processing block
// ----------------------------------------------------------------------------
// Notes on behaviour
// - unread sample sets the word's new flag
// - fault flag high while any diagnostic flag set
// - rate 14 bits, weight follows selected range
// - angle accumulates, wraps after full circle
// - temperature 12-bit signed, zero means 25 C
// - period field zero gives 2048 samples/s
// - otherwise period is base times count+1
// - range codes 100, 010, 001
// - lower ranges force minimum tap code
// - pole bit selects wide or narrow bandwidth
// - two cascaded moving-average stages
// - each stage holds 2^m taps
// - signed offset trim added to rate
// - unsigned scale trim multiplies rate, 0x800 is unity
// ----------------------------------------------------------------------------
`default_nettype none
package rsp_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned FAST_SPS = 2048;
  localparam int unsigned FAST_CYC = CLK_HZ / FAST_SPS;
  localparam int unsigned TB_SHORT_NS = 1_953_000;
  localparam int unsigned TB_LONG_NS = 60_540_000;
  localparam int unsigned TB_SHORT_CYC = TB_SHORT_NS / 1000 * CLK_MHZ;
  localparam int unsigned TB_LONG_CYC = TB_LONG_NS / 1000 * CLK_MHZ;
  // one angle step is two trim-weight rate steps held for one second
  localparam int unsigned ANGLE_PER_RATE = 2;
  localparam int unsigned ANGLE_UNIT = ANGLE_PER_RATE * CLK_HZ;
  localparam logic [13:0] ANGLE_MAX = 14'h2663;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [6:0] A_SUPPLY = 7'h02;
  localparam logic [6:0] A_RATE = 7'h04;
  localparam logic [6:0] A_AUX = 7'h0A;
  localparam logic [6:0] A_TEMP = 7'h0C;
  localparam logic [6:0] A_ANGLE = 7'h0E;
  localparam logic [6:0] A_OFF = 7'h14;
  localparam logic [6:0] A_SCALE = 7'h16;
  localparam logic [6:0] A_SMPL = 7'h36;
  localparam logic [6:0] A_SENS = 7'h38;
  localparam logic [6:0] A_DIAG = 7'h3C;
  localparam logic [6:0] A_IRQ_ST = 7'h60;
  localparam logic [6:0] A_IRQ_MASK = 7'h62;
  localparam logic [15:0] SMPL_RST = 16'h0001;
  localparam logic [15:0] SENS_RST = 16'h0402;
  localparam logic [11:0] OFF_RST = 12'h000;
  localparam logic [11:0] SCALE_RST = 12'h800;
  // ------------------------------------------------------------
  // fields
  // ------------------------------------------------------------
  localparam int SP_BASE_BIT = 7;
  localparam int SA_POLE_BIT = 7;
  localparam logic [2:0] RANGE_320 = 3'h4;
  localparam logic [2:0] RANGE_160 = 3'h2;
  localparam logic [2:0] RANGE_80 = 3'h1;
  localparam logic [2:0] MIN_TAP_160 = 3'h2;
  localparam logic [2:0] MIN_TAP_80 = 3'h4;
  localparam logic [1:0] SH_320 = 2'h2;
  localparam logic [1:0] SH_160 = 2'h1;
  localparam logic [1:0] SH_80 = 2'h0;
  localparam int SCALE_FRAC = 11;
  localparam logic signed [20:0] RATE_POS = 21'sh001FFF;
  localparam logic signed [20:0] RATE_NEG = -21'sh002000;
  localparam int IRQ_SAMPLE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_W = 2;

  typedef struct packed {
    logic new_sample_flag;
    logic fault_summary_flag;
    logic [13:0] data;
  } rsp_word_t;

  typedef struct packed {
    logic [2:0] range;
    logic pole;
    logic [2:0] taps;
  } rsp_sens_t;
endpackage
`default_nettype wire

// *** rsp_monitor.sv ***
// port checker of the rate sensor output processing block
`timescale 1ns/1ps
`default_nettype none
module rsp_monitor #(
  parameter int unsigned FAST_CYC = 20
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // register port
  input wire logic [6:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  // sensor side
  input wire logic [15:0] DIAG_I,
  input wire logic POLE_WIDE_O,
  input wire logic SAMPLE_O,
  input wire logic IRQ_O
);
  // ----------------
  // helpers
  // ----------------
  logic sens_wr;
  logic sens_rd;
  logic rate_rd;
  logic fault;
  logic [2:0] wr_range;
  logic [31:0] gap_reg;
  logic armed_reg;
  logic wrote_reg;
  assign sens_wr = WR_I && ADDR_I == rsp_pkg::A_SENS;
  assign sens_rd = RD_I && ADDR_I == rsp_pkg::A_SENS;
  assign rate_rd = RD_I && ADDR_I == rsp_pkg::A_RATE;
  assign fault = |DIAG_I;
  assign wr_range = WDATA_I[10:8];
  // a write may retune the period, so a gap spanning one is not judged
  always_ff @(posedge CLOCK_I) begin
    if (RST_I || SAMPLE_O) begin
      gap_reg <= 32'h0;
      wrote_reg <= 1'b0;
    end else begin
      gap_reg <= gap_reg + 32'h1;
      wrote_reg <= wrote_reg | WR_I;
    end
  end
  always_ff @(posedge CLOCK_I) begin
    armed_reg <= !RST_I && (armed_reg || SAMPLE_O);
  end
  // ----------------
  // assertions
  // ----------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence s_tap_wr;
    sens_wr && wr_range inside {3'h1, 3'h2};
  endsequence
  sequence s_two_rate_reads;
    rate_rd ##1 rate_rd ##1 1'b1;
  endsequence
  AST_READ_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data not zero outside answer cycle");
  AST_SAMPLE_PULSE: assert property (SAMPLE_O |=> !SAMPLE_O)
    else $error("sample pulse longer than one cycle");
  AST_SAMPLE_GAP: assert property (SAMPLE_O && armed_reg && !wrote_reg && !WR_I
    |-> gap_reg >= FAST_CYC - 1) else $error("samples closer than fastest period");
  AST_POLE_FOLLOW: assert property (sens_wr |=> POLE_WIDE_O == $past(WDATA_I[7]))
    else $error("pole output differs from written bit");
  AST_POLE_HOLD: assert property ($changed(POLE_WIDE_O) |-> $past(sens_wr))
    else $error("pole output moved without a write");
  AST_TAP_MIN: assert property (s_tap_wr ##2 sens_rd |=>
    RDATA_O[2:0] >= ($past(wr_range, 3) == 3'h1 ? 3'h4 : 3'h2))
    else $error("tap field below range minimum");
  AST_FAULT_BIT: assert property ($past(rate_rd) |-> RDATA_O[14] == $past(fault))
    else $error("fault bit differs from diagnostic flags");
  AST_NEW_CLEARED: assert property (!$past(SAMPLE_O) ##0
    (!SAMPLE_O throughout s_two_rate_reads) |-> !RDATA_O[15])
    else $error("new flag still set on repeated read");
  AST_IRQ_CAUSE: assert property ($rose(IRQ_O) |-> $past(SAMPLE_O) || $past(WR_I) || fault)
    else $error("interrupt rose without an event");
endmodule

bind rsp_top rsp_monitor #(.FAST_CYC(FAST_CYC)) mon (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .DIAG_I(DIAG_I), .POLE_WIDE_O(POLE_WIDE_O), .SAMPLE_O(SAMPLE_O), .IRQ_O(IRQ_O));
`default_nettype wire

// *** rsp_host.sv ***
// host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module rsp_host (
  // clock
  input wire logic clk_i,
  // register port
  output logic [6:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [15:0] rdata_i
);
  initial begin
    addr_o = 7'h00;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  // two keeps the strobe up a second cycle for back-to-back reads
  task automatic rd(input logic [6:0] a, input logic two, output logic [15:0] d1,
                    output logic [15:0] d2);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= two;
    @(posedge clk_i);
    rd_o <= 1'b0;
    d1 = rdata_i;
    @(posedge clk_i);
    d2 = rdata_i;
  endtask
  // range goes first since it may raise the tap field
  task automatic set_sens(input logic [2:0] rng, input logic pole, input logic [2:0] taps);
    wr(rsp_pkg::A_SENS, {5'h00, rng, 8'h00});
    wr(rsp_pkg::A_SENS, {5'h00, rng, pole, 4'h0, taps});
  endtask
endmodule
`default_nettype wire

// *** test_rsp_top.sv ***
// self-checking testbench of the rate sensor output processing block
`timescale 1ns/1ps
`default_nettype none
module test_rsp_top;
  localparam int FAST = 20;
  localparam int SHORT = 30;
  localparam int LONG = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic signed [15:0] raw = 16'sh0000;
  logic [11:0] supply = 12'h000;
  logic [11:0] temp = 12'h000;
  logic [11:0] aux = 12'h000;
  logic [15:0] diag = 16'h0000;
  logic pole;
  logic smp;
  logic irq;
  logic [15:0] d1;
  logic [15:0] d2;
  int bad_count = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  rsp_host host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));
  rsp_top #(.FAST_CYC(FAST), .TB_SHORT_CYC(SHORT), .TB_LONG_CYC(LONG), .ANGLE_UNIT(1000)) dut (
    .CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .RATE_RAW_I(raw), .SUPPLY_I(supply), .TEMP_I(temp), .AUX_I(aux),
    .DIAG_I(diag), .POLE_WIDE_O(pole), .SAMPLE_O(smp), .IRQ_O(irq));
  // ----------------
  // helpers
  // ----------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_smp(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 5000) begin
        bad_count++;
        final_report();
      end
    end while (smp !== 1'b1);
  endtask
  task automatic samples(input int k);
    int n;
    repeat (k) wait_smp(n);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset();
    logic [6:0] a [5] = '{rsp_pkg::A_SMPL, rsp_pkg::A_SENS, rsp_pkg::A_OFF,
                          rsp_pkg::A_SCALE, 7'h40};
    logic [15:0] e [5] = '{16'h0001, 16'h0402, 16'h0000, 16'h0800, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      host.rd(a[i], 1'b0, d1, d2);
      check(d1, e[i]);
    end
    check({15'h0, pole}, 16'h0000);
  endtask
  task automatic t_sens();
    host.set_sens(3'h1, 1'b0, 3'h0);
    host.rd(rsp_pkg::A_SENS, 1'b0, d1, d2);
    check(d1, 16'h0104);
    host.set_sens(3'h2, 1'b1, 3'h0);
    host.rd(rsp_pkg::A_SENS, 1'b0, d1, d2);
    check(d1, 16'h0282);
    check({15'h0, pole}, 16'h0001);
    host.set_sens(3'h4, 1'b0, 3'h0);
    @(negedge clk);
    check({15'h0, pole}, 16'h0000);
  endtask
  task automatic t_period();
    int n;
    logic [7:0] s [3] = '{8'h00, 8'h03, 8'h81};
    int p [3] = '{FAST, SHORT * 4, LONG * 2};
    for (int i = 0; i < 3; i++) begin
      host.wr(rsp_pkg::A_SMPL, {8'h00, s[i]});
      samples(2);
      wait_smp(n);
      check(16'(n), 16'(p[i]));
    end
    host.wr(rsp_pkg::A_SMPL, 16'h0000);
  endtask
  task automatic t_rate();
    logic [15:0] r [4] = '{-16'sd400, -16'sd400, 16'sd400, 16'sd400};
    logic [15:0] o [4] = '{16'h0000, 16'h0004, 16'h0000, 16'h0000};
    logic [15:0] g [4] = '{16'h0800, 16'h0800, 16'h0000, 16'h0C00};
    logic [15:0] e [4] = '{16'hBF9C, 16'hBF9D, 16'h8000, 16'h8096};
    @(posedge clk);
    raw <= 16'sd400;
    samples(4);
    host.rd(rsp_pkg::A_RATE, 1'b1, d1, d2);
    check(d1, 16'h8064);
    check(d2, 16'h0064);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      raw <= r[i];
      host.wr(rsp_pkg::A_OFF, o[i]);
      host.wr(rsp_pkg::A_SCALE, g[i]);
      samples(4);
      host.rd(rsp_pkg::A_RATE, 1'b0, d1, d2);
      check(d1, e[i]);
    end
    host.wr(rsp_pkg::A_SCALE, 16'h0800);
  endtask
  task automatic t_filter();
    host.set_sens(3'h1, 1'b0, 3'h0);
    samples(8);
    host.rd(rsp_pkg::A_RATE, 1'b0, d1, d2);
    check({15'h0, d1[13:0] < 14'd400}, 16'h0001);
    samples(40);
    host.rd(rsp_pkg::A_RATE, 1'b0, d1, d2);
    check(d1, 16'h8190);
    host.set_sens(3'h2, 1'b0, 3'h0);
    samples(12);
    host.rd(rsp_pkg::A_RATE, 1'b0, d1, d2);
    check(d1, 16'h80C8);
    host.set_sens(3'h4, 1'b0, 3'h0);
    samples(4);
  endtask
  task automatic t_conv();
    @(posedge clk);
    supply <= 12'hB33;
    aux <= 12'hFFF;
    temp <= 12'hE41;
    samples(2);
    host.rd(rsp_pkg::A_SUPPLY, 1'b0, d1, d2);
    check(d1, 16'h8B33);
    host.rd(rsp_pkg::A_AUX, 1'b0, d1, d2);
    check(d1, 16'h8FFF);
    host.rd(rsp_pkg::A_TEMP, 1'b0, d1, d2);
    check({4'h0, d1[11:0]}, 16'h0E41);
    @(posedge clk);
    diag <= 16'h0004;
    host.rd(rsp_pkg::A_RATE, 1'b0, d1, d2);
    check({15'h0, d1[14]}, 16'h0001);
    host.rd(rsp_pkg::A_DIAG, 1'b0, d1, d2);
    check(d1, 16'h0004);
    @(posedge clk);
    diag <= 16'h0000;
    host.rd(rsp_pkg::A_RATE, 1'b0, d1, d2);
    check({15'h0, d1[14]}, 16'h0000);
  endtask
  task automatic t_angle();
    host.wr(rsp_pkg::A_ANGLE, 16'h2663);
    repeat (10) @(posedge clk);
    host.rd(rsp_pkg::A_ANGLE, 1'b0, d1, d2);
    check({15'h0, d1[13:0] < 14'h0010}, 16'h0001);
    @(posedge clk);
    raw <= -16'sd400;
    samples(4);
    host.wr(rsp_pkg::A_ANGLE, 16'h0000);
    repeat (10) @(posedge clk);
    host.rd(rsp_pkg::A_ANGLE, 1'b0, d1, d2);
    check({15'h0, d1[13:0] > 14'h2650}, 16'h0001);
  endtask
  task automatic t_irq();
    host.wr(rsp_pkg::A_IRQ_ST, 16'h0003);
    host.wr(rsp_pkg::A_IRQ_MASK, 16'h0001);
    samples(1);
    @(negedge clk);
    check({15'h0, irq}, 16'h0001);
    host.wr(rsp_pkg::A_IRQ_MASK, 16'h0002);
    host.wr(rsp_pkg::A_IRQ_ST, 16'h0003);
    @(negedge clk);
    check({15'h0, irq}, 16'h0000);
    @(posedge clk);
    diag <= 16'h0004;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({15'h0, irq}, 16'h0001);
    host.rd(rsp_pkg::A_IRQ_ST, 1'b0, d1, d2);
    check({15'h0, d1[rsp_pkg::IRQ_FAULT]}, 16'h0001);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_sens();
    t_period();
    t_rate();
    t_filter();
    t_conv();
    t_angle();
    t_irq();
    final_report();
  end
endmodule
`default_nettype wire
